// >>> dv/watchdog_timeout_unit_test.sv
`timescale 1ns/1ps
module watchdog_timeout_unit_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic crystal_input, system_reset, irq;
  logic [7:0] paddr, nv_protect_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] protect_byte_addr;
  int errors, n_compared, pulses;
  localparam logic [7:0] CTRL = wdt_pkg::CTRL_OFFSET;
  localparam logic [7:0] STAT = wdt_pkg::IRQ_STATUS_OFFSET;
  localparam logic [7:0] CLR = wdt_pkg::IRQ_CLEAR_OFFSET;
  localparam logic [7:0] ENA = wdt_pkg::IRQ_ENABLE_OFFSET;
  ////////////////////////////////////////////////////////////////////////////
  watchdog_timeout_unit dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_input(crystal_input), .nv_protect_byte(nv_protect_byte), .protect_byte_addr(protect_byte_addr),
    .system_reset(system_reset), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // the master never assumes a latency: it waits on pready, bounded only against a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask : apb
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic wr_ctrl(input logic [31:0] v);
    apb(1'b1, CTRL, 32'h1);
    apb(1'b1, CTRL, v);
  endtask : wr_ctrl
  // crystal edges far slower than pclk so the synchroniser sees every one
  task automatic crystal(input int n);
    repeat (n) begin
      @(posedge pclk);
      crystal_input <= 1'b1;
      repeat (4) @(posedge pclk);
      crystal_input <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : crystal
  task automatic count_pulse();
    pulses = 0;
    repeat (30) begin
      @(posedge pclk);
      if (system_reset === 1'b1) pulses++;
    end
  endtask : count_pulse
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk("ctrl reset", CTRL, 32'h72);
    chk("protect addr", 32'h3ffa, {18'h0, protect_byte_addr});
    rdchk("irq enable reset", ENA, 32'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask : t_reset
  task automatic t_lock();
    apb(1'b1, CTRL, 32'h0);
    rdchk("ctrl locked", CTRL, 32'h72);
    rdchk("refused flag", STAT, 32'h2);
    apb(1'b1, STAT, 32'h0);
    rdchk("status read only", STAT, 32'h2);
    apb(1'b1, CTRL, 32'h1);
    apb(1'b0, STAT, 32'h0);
    apb(1'b1, CTRL, 32'h0a);
    rdchk("unlock spent", CTRL, 32'h72);
    apb(1'b1, CLR, 32'h3);
    rdchk("status cleared", STAT, 32'h0);
  endtask : t_lock
  task automatic t_irq();
    apb(1'b1, ENA, 32'h1);
    wr_ctrl(32'h0a);
    rdchk("ctrl unlocked", CTRL, 32'h0a);
    crystal(300);
    wr_ctrl(32'h0a);
    crystal(511);
    rdchk("no early expiry", CTRL, 32'h0a);
    crystal(1);
    repeat (8) @(posedge pclk);
    rdchk("ctrl expired", CTRL, 32'h0e);
    rdchk("timeout irq bit", STAT, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    chk("no reset", 32'h0, {31'h0, system_reset});
    apb(1'b1, CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr_ctrl(32'h08);
    crystal(600);
    rdchk("disabled", CTRL, 32'h08);
    rdchk("no timeout", STAT, 32'h0);
  endtask : t_irq
  task automatic t_reset_resp();
    wr_ctrl(32'h02);
    crystal(511);
    rdchk("not yet", CTRL, 32'h02);
    fork
      crystal(1);
      count_pulse();
    join
    chk("reset pulse", 32'h4, pulses);
    rdchk("status kept", CTRL, 32'h76);
    do_reset();
    rdchk("pin reset clears", CTRL, 32'h72);
  endtask : t_reset_resp
  task automatic t_codes();
    apb(1'b1, CTRL, 32'h1);
    fork
      apb(1'b1, CTRL, 32'h92);
      count_pulse();
    join
    chk("code 9 reset", 32'h4, pulses);
    rdchk("code 9 status kept", CTRL, 32'h76);
    wr_ctrl(32'h1a);
    crystal(1023);
    rdchk("code 1 not yet", STAT, 32'h0);
    crystal(1);
    repeat (8) @(posedge pclk);
    rdchk("code 1 expired", STAT, 32'h1);
    wr_ctrl(32'ha2);
    crystal(520);
    rdchk("invalid code idle", CTRL, 32'ha2);
  endtask : t_codes
  task automatic t_protect();
    nv_protect_byte <= 8'h7f;
    do_reset();
    wr_ctrl(32'h38);
    rdchk("protected ctrl", CTRL, 32'h32);
    apb(1'b1, CTRL, 32'h1);
    fork
      apb(1'b1, CTRL, 32'h80);
      count_pulse();
    join
    chk("immediate reset", 32'h4, pulses);
    nv_protect_byte <= 8'hff;
    do_reset();
  endtask : t_protect
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    crystal_input = 1'b0;
    nv_protect_byte = 8'hff;
    errors = 0;
    n_compared = 0;
    do_reset();
    t_reset();
    t_lock();
    t_irq();
    t_reset_resp();
    t_codes();
    t_protect();
    give_verdict();
  end
  // the run needs about 30000 cycles; twice that means a hang
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule : watchdog_timeout_unit_test

// >>> verilog/crystal_edge_sync.sv
`timescale 1ns/1ps
module crystal_edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // crystal pin and its rising edge
  input wire logic crystal_input,
  output logic rise_tick
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // the first stage feeds only the second; the edge uses the settled copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= crystal_input;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise_tick = sync_reg & ~prev_reg;
endmodule : crystal_edge_sync

// >>> verilog/watchdog_timeout_unit.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
module watchdog_timeout_unit #(
  parameter int COUNTER_WIDTH = 16,
  parameter int ADDR_WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // crystal and non-volatile protection byte
  input wire logic crystal_input,
  input wire logic [7:0] nv_protect_byte,
  output logic [13:0] protect_byte_addr,
  // system outputs
  output logic system_reset,
  output logic irq
);
  localparam int PULSE_WIDTH = $clog2(wdt_pkg::RESET_PULSE_CYCLES + 1);

  logic tick;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic unlock_reg;
  logic enable_reg;
  logic response_reg;
  logic status_reg;
  logic [3:0] pre_reg;
  logic [COUNTER_WIDTH-1:0] count_reg;
  logic prot_reg;
  logic prot_taken_reg;
  logic [wdt_pkg::IRQ_WIDTH-1:0] irq_status_reg;
  logic [wdt_pkg::IRQ_WIDTH-1:0] irq_enable_reg;
  logic irq_reg;
  logic system_reset_reg;
  logic [PULSE_WIDTH-1:0] pulse_cnt_reg;
  logic [13:0] protect_addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] off);
    return a == ADDR_WIDTH'(off);
  endfunction : addr_is

  // all ones below the selected output bit; valid for codes up to 7 only
  function automatic logic [COUNTER_WIDTH-1:0] timeout_mask(input logic [3:0] pre);
    logic [COUNTER_WIDTH:0] full;
    full = {{COUNTER_WIDTH{1'b0}}, 1'b1} << (pre + wdt_pkg::TIMEOUT_BASE_SHIFT);
    full = full - {{COUNTER_WIDTH{1'b0}}, 1'b1};
    return full[COUNTER_WIDTH-1:0];
  endfunction : timeout_mask

  ////////////////////////////////////////////////////////////////////////////
  // crystal edge, two flops deep
  crystal_edge_sync u_crystal_sync (
    .pclk(pclk),
    .presetn(presetn),
    .crystal_input(crystal_input),
    .rise_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic setup;
  logic done;
  logic mapped;
  logic wr_ctrl;
  logic unlock_req;
  logic ctrl_apply;
  logic locked_write;
  logic kick;

  assign setup = psel & ~penable;
  assign done = psel & penable & pready_reg;
  assign mapped = addr_is(paddr, wdt_pkg::CTRL_OFFSET) | addr_is(paddr, wdt_pkg::IRQ_STATUS_OFFSET) |
                  addr_is(paddr, wdt_pkg::IRQ_CLEAR_OFFSET) | addr_is(paddr, wdt_pkg::IRQ_ENABLE_OFFSET);
  assign wr_ctrl = done & pwrite & addr_is(paddr, wdt_pkg::CTRL_OFFSET);
  // unlock write only arms; its other bits are dropped
  assign unlock_req = wr_ctrl & pwdata[wdt_pkg::UNLOCK_BIT] & ~unlock_reg;
  assign ctrl_apply = wr_ctrl & unlock_reg;
  assign locked_write = wr_ctrl & ~unlock_reg & ~pwdata[wdt_pkg::UNLOCK_BIT];
  assign kick = ctrl_apply & pwdata[wdt_pkg::ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // timeout detection
  logic pre_timed;
  logic pre_instant;
  logic expire;
  logic expire_reset;
  logic expire_irq;

  assign pre_timed = pre_reg <= wdt_pkg::PRE_MAX_TIMED;
  assign pre_instant = (pre_reg == wdt_pkg::PRE_AUTO_RESET) | (pre_reg == wdt_pkg::PRE_DOWNLOAD_RESET);
  // codes 10 to 15 never time out; a disabled watchdog never fires
  assign expire = enable_reg & ((pre_timed & tick & ((count_reg & timeout_mask(pre_reg)) == timeout_mask(pre_reg)))
                  | pre_instant);
  assign expire_reset = expire & (~response_reg | pre_instant);
  assign expire_irq = expire & ~expire_reset;

  ////////////////////////////////////////////////////////////////////////////
  // apb answer, one wait-free access phase after the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= ~mapped;
        prdata_reg <= 32'h0;
        if (!pwrite && addr_is(paddr, wdt_pkg::CTRL_OFFSET)) begin
          prdata_reg <= {24'h0, pre_reg, response_reg, status_reg, enable_reg, unlock_reg};
        end else if (!pwrite && addr_is(paddr, wdt_pkg::IRQ_STATUS_OFFSET)) begin
          prdata_reg <= {{(32 - wdt_pkg::IRQ_WIDTH){1'b0}}, irq_status_reg};
        end else if (!pwrite && addr_is(paddr, wdt_pkg::IRQ_ENABLE_OFFSET)) begin
          prdata_reg <= {{(32 - wdt_pkg::IRQ_WIDTH){1'b0}}, irq_enable_reg};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_reg <= 1'b0;
    end else if (expire_reset) begin
      unlock_reg <= 1'b0;
    end else if (done) begin
      unlock_reg <= unlock_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection strap, taken in the first cycle after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_reg <= 1'b0;
      prot_taken_reg <= 1'b0;
      protect_addr_reg <= wdt_pkg::PROTECT_FLASH_ADDR;
    end else if (!prot_taken_reg) begin
      prot_reg <= ~nv_protect_byte[wdt_pkg::PROTECT_BIT];
      prot_taken_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control fields; a watchdog reset restores them but keeps the status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= wdt_pkg::ENABLE_RESET;
      response_reg <= wdt_pkg::RESPONSE_RESET;
      pre_reg <= wdt_pkg::PRE_RESET;
    end else if (expire_reset) begin
      enable_reg <= wdt_pkg::ENABLE_RESET;
      response_reg <= wdt_pkg::RESPONSE_RESET;
      pre_reg <= wdt_pkg::PRE_RESET;
    end else begin
      if (ctrl_apply) begin
        pre_reg <= pwdata[wdt_pkg::PRE_MSB:wdt_pkg::PRE_LSB];
      end
      if (prot_reg) begin
        enable_reg <= 1'b1;
        response_reg <= 1'b0;
      end else if (ctrl_apply) begin
        enable_reg <= pwdata[wdt_pkg::ENABLE_BIT];
        response_reg <= pwdata[wdt_pkg::RESPONSE_BIT];
      end
    end
  end

  // a pin reset or an unlocked control write with bit 2 low clears the flag; a new timeout beats a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= wdt_pkg::STATUS_RESET;
    end else if (expire) begin
      status_reg <= 1'b1;
    end else if (ctrl_apply && !pwdata[wdt_pkg::STATUS_BIT]) begin
      status_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, advanced by crystal edges only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else if (expire || kick) begin
      count_reg <= '0;
    end else if (tick && enable_reg) begin
      count_reg <= count_reg + COUNTER_WIDTH'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system reset pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_reg <= '0;
      system_reset_reg <= 1'b0;
    end else begin
      system_reset_reg <= expire_reset | (pulse_cnt_reg > PULSE_WIDTH'(1));
      if (expire_reset) begin
        pulse_cnt_reg <= PULSE_WIDTH'(wdt_pkg::RESET_PULSE_CYCLES);
      end else if (pulse_cnt_reg != '0) begin
        pulse_cnt_reg <= pulse_cnt_reg - PULSE_WIDTH'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable
  logic [wdt_pkg::IRQ_WIDTH-1:0] irq_set;
  logic [wdt_pkg::IRQ_WIDTH-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[wdt_pkg::IRQ_TIMEOUT_BIT] = expire_irq;
    irq_set[wdt_pkg::IRQ_LOCKED_WRITE_BIT] = locked_write;
    irq_clr = '0;
    if (done && pwrite && addr_is(paddr, wdt_pkg::IRQ_CLEAR_OFFSET)) begin
      irq_clr = pwdata[wdt_pkg::IRQ_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
      irq_enable_reg <= wdt_pkg::IRQ_ENABLE_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      if (done && pwrite && addr_is(paddr, wdt_pkg::IRQ_ENABLE_OFFSET)) begin
        irq_enable_reg <= pwdata[wdt_pkg::IRQ_WIDTH-1:0];
      end
      irq_reg <= |(irq_status_reg & irq_enable_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign protect_byte_addr = protect_addr_reg;
  assign system_reset = system_reset_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence reset_pulse_s;
    system_reset_reg [*4] ##1 !system_reset_reg;
  endsequence

  sequence irq_raised_s;
    !system_reset_reg && irq_status_reg[wdt_pkg::IRQ_TIMEOUT_BIT] && status_reg;
  endsequence

  sequence unlock_armed_s;
    unlock_req && !expire_reset;
  endsequence

  sequence protected_write_s;
    prot_reg && ctrl_apply && !expire_reset;
  endsequence

  reset_pulse_a: assert property (expire_reset |=> reset_pulse_s)
    else $error("reset response pulse wrong");
  irq_response_a: assert property (expire_irq && !system_reset_reg |=> irq_raised_s)
    else $error("interrupt response wrong");
  unlock_drop_a: assert property (done && unlock_reg |=> !unlock_reg)
    else $error("unlock state outlived next access");
  locked_write_a: assert property (locked_write && !expire_reset |=> pre_reg == $past(pre_reg))
    else $error("control changed without unlock");
  protect_force_a: assert property (prot_reg |=> enable_reg && !response_reg)
    else $error("protection not forcing control");
  status_set_a: assert property (expire |=> status_reg)
    else $error("timeout status not set");
  kick_clear_a: assert property (kick |=> count_reg == '0)
    else $error("counter not cleared by enable write");
  defaults_a: assert property (expire_reset |=> pre_reg == wdt_pkg::PRE_RESET && enable_reg)
    else $error("watchdog reset did not restore defaults");
  crystal_step_a: assert property (!tick && !kick && !expire |=> count_reg == $past(count_reg))
    else $error("counter moved without crystal edge");
  disabled_quiet_a: assert property (!enable_reg && !kick |=> count_reg == $past(count_reg))
    else $error("disabled watchdog counter moved");
  irq_level_a: assert property (|(irq_status_reg & irq_enable_reg) |=> irq_reg)
    else $error("interrupt output not raised");

  // protection, timing and bus side; the two shortest timeouts, codes 0 and 1, are the ones tests can reach
  protect_pre_a: assert property (protected_write_s |=>
    pre_reg == $past(pwdata[wdt_pkg::PRE_MSB:wdt_pkg::PRE_LSB]) && enable_reg && !response_reg)
    else $error("protected write mishandled");
  protect_sample_a: assert property (!prot_taken_reg |=>
    prot_reg != $past(nv_protect_byte[wdt_pkg::PROTECT_BIT]))
    else $error("protection strap misread");
  protect_hold_a: assert property (prot_taken_reg |=> $stable(prot_reg))
    else $error("protection changed after reset");
  min_period_a: assert property (pre_timed && tick &&
    count_reg[wdt_pkg::TIMEOUT_BASE_SHIFT-1:0] != '1 |-> !expire)
    else $error("timeout before shortest period");
  base_expiry_a: assert property (enable_reg && tick && pre_reg == 4'h0 &&
    count_reg[wdt_pkg::TIMEOUT_BASE_SHIFT-1:0] == '1 |-> expire)
    else $error("shortest timeout missed");
  count_step_a: assert property (tick && enable_reg && !expire && !kick |=>
    count_reg == $past(count_reg) + COUNTER_WIDTH'(1))
    else $error("counter missed a crystal edge");
  status_clear_a: assert property (ctrl_apply && !pwdata[wdt_pkg::STATUS_BIT] && !expire |=> !status_reg)
    else $error("status not cleared by write");
  reset_source_a: assert property (!expire_reset && !system_reset_reg |=> !system_reset_reg)
    else $error("system reset without timeout");
  locked_ctrl_a: assert property (locked_write && !expire |=>
    enable_reg == $past(enable_reg) && response_reg == $past(response_reg))
    else $error("locked write changed control");
  unlock_arm_a: assert property (unlock_armed_s |=> unlock_reg)
    else $error("unlock step not armed");
  irq_drop_a: assert property (!(|(irq_status_reg & irq_enable_reg)) |=> !irq_reg)
    else $error("interrupt output stuck");
endmodule : watchdog_timeout_unit

// >>> verilog/wdt_pkg.sv
package wdt_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets on the bus
  localparam logic [7:0] CTRL_OFFSET = 8'hc0;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'hc4;
  localparam logic [7:0] IRQ_CLEAR_OFFSET = 8'hc8;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'hcc;
  ////////////////////////////////////////////////////////////////////////////
  // watchdog_control field positions
  localparam int UNLOCK_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int STATUS_BIT = 2;
  localparam int RESPONSE_BIT = 3;
  localparam int PRE_LSB = 4;
  localparam int PRE_MSB = 7;
  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [3:0] PRE_RESET = 4'h7;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic RESPONSE_RESET = 1'b0;
  localparam logic STATUS_RESET = 1'b0;
  localparam logic [1:0] IRQ_ENABLE_RESET = 2'h0;
  ////////////////////////////////////////////////////////////////////////////
  // prescaler codes
  localparam logic [3:0] PRE_MAX_TIMED = 4'h7;
  localparam logic [3:0] PRE_AUTO_RESET = 4'h8;
  localparam logic [3:0] PRE_DOWNLOAD_RESET = 4'h9;
  localparam int TIMEOUT_BASE_SHIFT = 9;
  ////////////////////////////////////////////////////////////////////////////
  // interrupt status bits
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_LOCKED_WRITE_BIT = 1;
  ////////////////////////////////////////////////////////////////////////////
  // non-volatile protection byte
  localparam logic [13:0] PROTECT_FLASH_ADDR = 14'h3ffa;
  localparam int PROTECT_BIT = 7;
  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_PULSE_NS = 400;
  localparam int RESET_PULSE_RAW = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_RAW < 1) ? 1 : RESET_PULSE_RAW;
endpackage : wdt_pkg
